/* hw/pscu_top.sv */
// synchronous-channel update logic with wishbone register slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "pscu_consts.svh"
module pscu_top
  import pscu_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                ce,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [31:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic                     wb_ack_o,
  output logic      [31:0]         wb_dat_o,
  input  wire logic [3:0]          sync_channel_select,
  input  wire pscu_mode_e          sync_update_mode,
  input  wire logic                dma_request_mode,
  input  wire logic [2:0]          dma_cmp_select,
  input  wire logic                period_start,
  input  wire logic [7:0]          cmp_match,
  input  wire logic [7:0]          cmp_updated,
  output logic [3:0][15:0]         channel_duty_value,
  output logic [3:0]               duty_load,
  output pscu_apply_s              update_apply,
  output logic                     dma_request,
  output pscu_override_s           override_value
);

  // bus decode
  logic        req;
  logic        wr;
  logic        rd;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic        wr_duty;
  logic        wr_ctrl;
  logic        wr_per;
  logic        wr_pbuf;
  logic        wr_en;
  logic        wr_dis;
  logic        wr_ovr;
  logic        rd_stat;

  // register state
  logic [3:0]  update_period_value;
  logic [3:0]  update_period_count;
  logic [3:0]  update_period_buffered;
  logic        pbuf_pending;
  logic        sync_update_unlock;
  logic [31:0] irq_mask;
  logic        write_ready_flag;
  logic        update_underrun_flag;
  logic [7:0]  comparison_match_flag;
  logic [7:0]  comparison_updated_flag;
  logic [3:0]  ovr_high;
  logic [3:0]  ovr_low;
  logic [1:0]  dma_ptr;
  logic        dma_pending;
  pscu_state_e state;
  pscu_state_e next_state;

  // update timing
  logic        auto_mode;
  logic        period_elapsed;
  logic        manual_done;
  logic        set_ready;
  logic        set_underrun;
  logic [31:0] next_rdata;
  logic [31:0] status_word;

  // a request is answered one cycle after it shows; ack then drops
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = req & wb_we_i;
  assign rd      = req & ~wb_we_i;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wd      = wb_dat_i & wmask;
  assign wr_duty = wr & (wb_adr_i == `PSCU_ADR_DUTY_PORT);
  assign wr_ctrl = wr & (wb_adr_i == `PSCU_ADR_UPD_CTRL);
  assign wr_per  = wr & (wb_adr_i == `PSCU_ADR_UPD_PERIOD);
  assign wr_pbuf = wr & (wb_adr_i == `PSCU_ADR_UPD_PBUF);
  assign wr_en   = wr & (wb_adr_i == `PSCU_ADR_IRQ_EN);
  assign wr_dis  = wr & (wb_adr_i == `PSCU_ADR_IRQ_DIS);
  assign wr_ovr  = wr & (wb_adr_i == `PSCU_ADR_OVERRIDE);
  assign rd_stat = rd & (wb_adr_i == `PSCU_ADR_IRQ_STAT);

  // automatic triggering only in modes 1 and 2
  assign auto_mode      = (sync_update_mode == PSCU_MODE_AUTO) |
                          (sync_update_mode == PSCU_MODE_DMA);
  // >= guards against a direct write lowering the value below the count
  assign period_elapsed = auto_mode & period_start &
                          (update_period_count >= update_period_value);
  assign manual_done    = (state == PSCU_ST_ARMED) & period_start;

  // search for the next synchronous channel at or after the pointer
  function automatic logic [2:0] next_sync(input logic [1:0] ptr, input logic [3:0] sel);
    logic [2:0] idx;
    idx = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      if (sel[i] && (2'(i) >= ptr)) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // later synchronous channel after a given one, for end of sequence
  function automatic logic more_after(input logic [1:0] ch, input logic [3:0] sel);
    logic any;
    any = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (sel[i] && (2'(i) > ch)) begin
        any = 1'b1;
      end
    end
    return any;
  endfunction

  // target channel for the next holding-port write
  logic [2:0] duty_idx;
  logic       duty_hit;
  assign duty_idx = next_sync(dma_ptr, sync_channel_select);
  assign duty_hit = wr_duty & ~duty_idx[2];

  // per-channel duty buffers loaded from the holding port
  for (genvar ch = 0; ch < `PSCU_NCH; ch++) begin : g_duty
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        channel_duty_value[ch] <= 16'h0000;
        duty_load[ch]          <= 1'b0;
      end else if (ce) begin
        duty_load[ch] <= duty_hit & (duty_idx[1:0] == 2'(ch));
        if (duty_hit && (duty_idx[1:0] == 2'(ch))) begin
          channel_duty_value[ch] <= wd[`PSCU_DUTY_W-1:0];
        end
      end
    end
  end

  // sequence pointer wraps after the last synchronous channel
  // with no synchronous channel the write is dropped and the pointer stays
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dma_ptr <= 2'h0;
    end else if (ce && duty_hit) begin
      if (more_after(duty_idx[1:0], sync_channel_select)) begin
        dma_ptr <= duty_idx[1:0] + 2'h1;
      end else begin
        dma_ptr <= 2'h0;
      end
    end
  end

  // a dma burst stays owed from request until its last channel lands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dma_pending <= 1'b0;
    end else if (ce) begin
      if (dma_request) begin
        dma_pending <= 1'b1;
      end else if (duty_hit && !more_after(duty_idx[1:0], sync_channel_select)) begin
        dma_pending <= 1'b0;
      end
    end
  end

  // unlock sequencer: armed until the next period start
  always_comb begin
    next_state = state;
    case (state)
      PSCU_ST_IDLE: begin
        if (wr_ctrl && wd[`PSCU_BIT_UNLOCK]) begin
          next_state = PSCU_ST_ARMED;
        end
      end
      PSCU_ST_ARMED: begin
        if (period_start) begin
          next_state = PSCU_ST_IDLE;
        end
      end
      default: begin
        next_state = PSCU_ST_IDLE;
      end
    endcase
  end

  // sequencer state; the unlock bit reads back as armed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state              <= PSCU_ST_IDLE;
      sync_update_unlock <= 1'b0;
    end else if (ce) begin
      state              <= next_state;
      sync_update_unlock <= (next_state == PSCU_ST_ARMED);
    end
  end

  // apply strobes toward the channels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      update_apply <= '0;
    end else if (ce) begin
      update_apply.period_dt <= manual_done;
      // duty follows unlock only in mode 0, else the update period
      update_apply.duty <= (manual_done & (sync_update_mode == PSCU_MODE_MANUAL)) |
                           period_elapsed;
    end
  end

  // update period counter and its double buffer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      update_period_count    <= `PSCU_RST_NIB;
      update_period_value    <= `PSCU_RST_NIB;
      update_period_buffered <= `PSCU_RST_NIB;
      pbuf_pending           <= 1'b0;
    end else if (ce) begin
      // a direct write beats the buffered load landing in the same edge
      if (wr_per) begin
        update_period_value <= (update_period_value & ~wmask[3:0]) | wd[3:0];
      end
      if (wr_pbuf) begin
        update_period_buffered <= wd[3:0];
        pbuf_pending           <= 1'b1;
      end
      if (period_elapsed) begin
        // restart; the count only moves in the automatic modes
        update_period_count <= `PSCU_RST_NIB;
        if (pbuf_pending && !wr_per) begin
          update_period_value <= update_period_buffered;
        end
        if (!wr_pbuf) begin
          pbuf_pending <= 1'b0;
        end
      end else if (auto_mode && period_start) begin
        update_period_count <= update_period_count + 4'h1;
      end
    end
  end

  // ready and dma request per mode and request mode
  // mode 0 and the unused code 3 never raise ready
  always_comb begin
    set_ready = 1'b0;
    case (sync_update_mode)
      PSCU_MODE_AUTO: begin
        set_ready = period_elapsed;
      end
      PSCU_MODE_DMA: begin
        if (dma_request_mode) begin
          set_ready = cmp_match[dma_cmp_select];
        end else begin
          set_ready = period_elapsed;
        end
      end
      default: begin
        set_ready = 1'b0;
      end
    endcase
  end

  // an update while the burst is still owed is an underrun
  assign set_underrun = period_elapsed & (sync_update_mode == PSCU_MODE_DMA) & dma_pending;

  // the transfer request exists only in mode 2
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dma_request <= 1'b0;
    end else if (ce) begin
      dma_request <= set_ready & (sync_update_mode == PSCU_MODE_DMA);
    end
  end

  // sticky status; a set in the read cycle wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_ready_flag        <= 1'b0;
      update_underrun_flag    <= 1'b0;
      comparison_match_flag   <= 8'h00;
      comparison_updated_flag <= 8'h00;
    end else if (ce) begin
      write_ready_flag        <= set_ready | (write_ready_flag & ~rd_stat);
      update_underrun_flag    <= set_underrun | (update_underrun_flag & ~rd_stat);
      comparison_match_flag   <= cmp_match | (comparison_match_flag & {8{~rd_stat}});
      comparison_updated_flag <= cmp_updated | (comparison_updated_flag & {8{~rd_stat}});
    end
  end

  // interrupt enables: disable first, enable last
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= `PSCU_RST_WORD;
    end else if (ce) begin
      irq_mask <= ((irq_mask & ~(wd & {32{wr_dis}})) | (wd & {32{wr_en}})) &
                  `PSCU_IRQ_BITS;
    end
  end

  // override levels for the output selector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovr_high <= `PSCU_RST_NIB;
      ovr_low  <= `PSCU_RST_NIB;
    end else if (ce && wr_ovr) begin
      ovr_high <= (ovr_high & ~wmask[`PSCU_OVH_LSB +: 4]) | wd[`PSCU_OVH_LSB +: 4];
      ovr_low  <= (ovr_low & ~wmask[`PSCU_OVL_LSB +: 4]) | wd[`PSCU_OVL_LSB +: 4];
    end
  end

  // registered override outputs, 1 drives high and 0 drives low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      override_value <= '0;
    end else if (ce) begin
      override_value.high <= ovr_high;
      override_value.low  <= ovr_low;
    end
  end

  // status word as read
  always_comb begin
    status_word                      = `PSCU_RST_WORD;
    status_word[`PSCU_BIT_WRITE_READY_FLAG]      = write_ready_flag;
    status_word[`PSCU_BIT_UPDATE_UNDERRUN_FLAG]      = update_underrun_flag;
    status_word[`PSCU_CMPM_LSB +: 8] = comparison_match_flag;
    status_word[`PSCU_CMPU_LSB +: 8] = comparison_updated_flag;
  end

  // read mux; write-only and unmapped words read as zero
  // a status read returns the flags as they stood before its own clear
  always_comb begin
    next_rdata = `PSCU_RST_WORD;
    case (wb_adr_i)
      `PSCU_ADR_UPD_CTRL: begin
        next_rdata[`PSCU_BIT_UNLOCK] = sync_update_unlock;
      end
      `PSCU_ADR_UPD_PERIOD: begin
        next_rdata[`PSCU_UPR_LSB +: 4] = update_period_value;
        next_rdata[`PSCU_CNT_LSB +: 4] = update_period_count;
      end
      `PSCU_ADR_IRQ_MASK: begin
        next_rdata = irq_mask;
      end
      `PSCU_ADR_IRQ_STAT: begin
        next_rdata = status_word;
      end
      `PSCU_ADR_OVERRIDE: begin
        next_rdata[`PSCU_OVH_LSB +: 4] = ovr_high;
        next_rdata[`PSCU_OVL_LSB +: 4] = ovr_low;
      end
      default: begin
        next_rdata = `PSCU_RST_WORD;
      end
    endcase
  end

  // bus answer, one wait-free cycle after the request shows
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `PSCU_RST_WORD;
    end else if (ce) begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule // pscu_top

/* include/pscu_consts.svh */
// constants for the synchronous-channel update block
// Functional notes
// - each duty port write loads the next synchronous channel's duty value
// - only the low 16 bits of the duty port are used
// - mode 0 unlock applies period, duty and dead-time at next period start
// - mode 1 or 2 unlock applies only period and dead-time values
// - the unlock bit clears itself once the update is done
// - automatic update every update period value plus one periods
// - update period counter reads back at bits 7 to 4
// - buffered update period holds a new value until it is applied
// - buffered update period matters only in modes 1 and 2
// - write ready flag at bit 0 shows new values may be written
// - underrun flag at bit 3 stays set until the status read
// - eight comparison match flags at bits 15 to 8
// - eight comparison update flags at bits 23 to 16
// - reading the status register clears all its flags
// - write-only enable register sets interrupt enables, status layout
// - write-only disable clears enables; read-only mask shows them
// - mode field selects manual, automatic or DMA-driven update method
// - mode 2 with request mode 1 raises ready on selected comparison match
// - override bit gives the level a channel output drives when selected
`ifndef PSCU_CONSTS_SVH
`define PSCU_CONSTS_SVH

`define PSCU_ADR_DUTY_PORT   32'h40020024
`define PSCU_ADR_UPD_CTRL    32'h40020028
`define PSCU_ADR_UPD_PERIOD  32'h4002002c
`define PSCU_ADR_UPD_PBUF    32'h40020030
`define PSCU_ADR_IRQ_EN      32'h40020034
`define PSCU_ADR_IRQ_DIS     32'h40020038
`define PSCU_ADR_IRQ_MASK    32'h4002003c
`define PSCU_ADR_IRQ_STAT    32'h40020040
`define PSCU_ADR_OVERRIDE    32'h40020044

`define PSCU_DUTY_W          16
`define PSCU_NCH             4
`define PSCU_NCMP            8
`define PSCU_BIT_UNLOCK      0
`define PSCU_UPR_LSB         0
`define PSCU_CNT_LSB         4
`define PSCU_BIT_WRITE_READY_FLAG        0
`define PSCU_BIT_UPDATE_UNDERRUN_FLAG        3
`define PSCU_CMPM_LSB        8
`define PSCU_CMPU_LSB        16
`define PSCU_OVH_LSB         0
`define PSCU_OVL_LSB         16
`define PSCU_IRQ_BITS        32'h00ffff09
`define PSCU_RST_WORD        32'h00000000
`define PSCU_RST_NIB         4'h0

`endif

/* include/pscu_pkg.sv */
// types shared by the synchronous-channel update block
package pscu_pkg;
  typedef enum logic [1:0] {
    PSCU_MODE_MANUAL = 2'h0,
    PSCU_MODE_AUTO   = 2'h1,
    PSCU_MODE_DMA    = 2'h2
  } pscu_mode_e;

  typedef enum logic [1:0] {
    PSCU_ST_IDLE  = 2'h1,
    PSCU_ST_ARMED = 2'h2
  } pscu_state_e;

  // one-cycle strobes telling the channels which buffers to copy
  typedef struct packed {
    logic duty;
    logic period_dt;
  } pscu_apply_s;

  typedef struct packed {
    logic [3:0] high;
    logic [3:0] low;
  } pscu_override_s;
endpackage

/* test/pscu_top_asserts.sv */
// concurrent checks on the ports of the synchronous-channel update block
`timescale 1ns/1ps
`include "pscu_consts.svh"
module pscu_top_asserts
  import pscu_pkg::*;
(
  input wire logic           clk,
  input wire logic           rstn,
  input wire logic           ce,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_we_i,
  input wire logic [31:0]    wb_adr_i,
  input wire logic [31:0]    wb_dat_i,
  input wire logic           wb_ack_o,
  input wire logic [3:0]     sync_channel_select,
  input wire pscu_mode_e     sync_update_mode,
  input wire logic           dma_request_mode,
  input wire logic [2:0]     dma_cmp_select,
  input wire logic           period_start,
  input wire logic [7:0]     cmp_match,
  input wire logic [3:0]     duty_load,
  input wire pscu_apply_s    update_apply,
  input wire logic           dma_request,
  input wire pscu_override_s override_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic       req;
  logic [7:0] ovr_exp;
  // a request counts only while ack is low, ack masks a held strobe
  assign req = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;

  // expected override pins, kept from the last override write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ovr_exp <= 8'h00;
    else if (req && wb_we_i && wb_adr_i == `PSCU_ADR_OVERRIDE) ovr_exp <= {wb_dat_i[3:0], wb_dat_i[19:16]};
  end

  a_ack_next:
    assert property (req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_once:
    assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_duty_sync:
    assert property (|duty_load |-> $onehot(duty_load) && !(duty_load & ~sync_channel_select))
      else $error("duty loaded into a free channel");
  a_ovr_pins:
    assert property (req && wb_we_i && wb_adr_i == `PSCU_ADR_OVERRIDE |-> ##[1:2] override_value == ovr_exp)
      else $error("override pins differ from written value");
  a_apply_start:
    assert property (update_apply.duty || update_apply.period_dt |-> $past(period_start))
      else $error("update applied away from a period start");
  a_manual_duty:
    assert property (update_apply.duty && sync_update_mode == PSCU_MODE_MANUAL |-> update_apply.period_dt)
      else $error("manual duty apply without period apply");
  a_dma_mode:
    assert property (dma_request |-> sync_update_mode == PSCU_MODE_DMA) else $error("request outside dma mode");
  a_dma_match:
    assert property (sync_update_mode == PSCU_MODE_DMA && dma_request_mode && cmp_match[dma_cmp_select]
                     |-> ##[1:2] dma_request) else $error("no transfer request after match");
endmodule // pscu_top_asserts

/* test/pscu_dma_model.sv */
// bus master standing in for the dma engine or processor
`timescale 1ns/1ps
module pscu_dma_model (
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [31:0]      adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  input  wire logic        ack,
  input  wire logic [31:0] rdat
);
  // idle bus at time zero
  initial begin
    {cyc, stb, we, sel} = 7'h00;
    {adr, dat} = 64'h0;
  end

  // one classic cycle, held until the edge that samples ack high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, sel} <= {2'b11, wr, 4'hf};
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb, we} <= 3'b000;
    // released lines must not keep showing the last value
    adr <= ~a;
    dat <= ~d;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask
endmodule // pscu_dma_model

/* test/pscu_top_tb.sv */
// self-checking bench for the synchronous-channel update block
`timescale 1ns/1ps
`include "pscu_consts.svh"
module pscu_top_tb
  import pscu_pkg::*;
;
  logic             clk, rstn, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, period_start;
  logic             dma_request_mode, dma_request;
  logic [31:0]      wb_adr_i, wb_dat_i, wb_dat_o, s, v, d, w, r;
  logic [3:0]       wb_sel_i, sync_channel_select, duty_load;
  logic [2:0]       dma_cmp_select;
  logic [7:0]       cmp_match, cmp_updated;
  logic [3:0][15:0] channel_duty_value;
  pscu_mode_e       sync_update_mode;
  pscu_apply_s      update_apply;
  pscu_override_s   override_value;
  int               num_errors, n_compared, nd, npd, nr, n, k, cyc_cnt;

  pscu_top u_dut (.clk, .rstn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
    .wb_dat_o, .sync_channel_select, .sync_update_mode, .dma_request_mode, .dma_cmp_select, .period_start,
    .cmp_match, .cmp_updated, .channel_duty_value, .duty_load, .update_apply, .dma_request, .override_value);
  pscu_dma_model u_dma (.clk, .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i), .adr(wb_adr_i), .sel(wb_sel_i),
    .dat(wb_dat_i), .ack(wb_ack_o), .rdat(wb_dat_o));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulse counters and hang guard, the run needs a few hundred cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (update_apply.duty) nd++;
    if (update_apply.period_dt) npd++;
    if (dma_request) nr++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      test_done();
    end
  end

  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_dma.rd(a, q);
    chk(nm, q, e);
  endtask

  // c period starts, each followed by room for the apply pulse to be counted
  task automatic pst(input int c);
    repeat (c) begin
      period_start <= 1'b1;
      @(posedge clk);
      period_start <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic evt(input logic [7:0] m, input logic [7:0] u);
    cmp_match <= m;
    cmp_updated <= u;
    @(posedge clk);
    {cmp_match, cmp_updated} <= 16'h0;
    @(posedge clk);
  endtask

  // period starts needed until the next automatic duty apply
  task automatic gap(output int g);
    int d0;
    d0 = nd;
    g = 0;
    while (nd == d0 && g < 20) begin
      pst(1);
      g++;
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {rstn, ce, dma_request_mode, period_start, dma_cmp_select} = 7'b0100000;
    {cmp_match, cmp_updated, sync_channel_select} = 20'h0;
    sync_update_mode = PSCU_MODE_MANUAL;
    s = 32'hc1a9;
    {num_errors, n_compared, nd, npd, nr, cyc_cnt} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // all nine registers plus one unmapped word read zero
    for (int a = 0; a < 10; a++) rdc("reset", `PSCU_ADR_DUTY_PORT + 4 * a, 32'h0);
    v = rnd();
    u_dma.wr(`PSCU_ADR_OVERRIDE, v);
    rdc("override", `PSCU_ADR_OVERRIDE, v & 32'h000f000f);
    chk("ovr_pins", {24'h0, override_value}, {24'h0, v[3:0], v[19:16]});
    v = rnd();
    d = rnd();
    u_dma.wr(`PSCU_ADR_IRQ_EN, v);
    rdc("mask_en", `PSCU_ADR_IRQ_MASK, v & `PSCU_IRQ_BITS);
    u_dma.wr(`PSCU_ADR_IRQ_DIS, d);
    rdc("mask_dis", `PSCU_ADR_IRQ_MASK, v & ~d & `PSCU_IRQ_BITS);
    $display("test registers finished");
    sync_channel_select <= 4'ha;
    w = rnd();
    u_dma.wr(`PSCU_ADR_DUTY_PORT, v);
    u_dma.wr(`PSCU_ADR_DUTY_PORT, d);
    u_dma.wr(`PSCU_ADR_DUTY_PORT, w);
    @(posedge clk);
    chk("duty1", {16'h0, channel_duty_value[1]}, {16'h0, w[15:0]});
    chk("duty3", {16'h0, channel_duty_value[3]}, {16'h0, d[15:0]});
    chk("duty0", {16'h0, channel_duty_value[0]}, 32'h0);
    chk("duty2", {16'h0, channel_duty_value[2]}, 32'h0);
    $display("test duty port finished");
    // a long update period keeps the counter from firing here
    u_dma.wr(`PSCU_ADR_UPD_PERIOD, 32'h7);
    for (int m = 0; m < 3; m++) begin
      sync_update_mode <= pscu_mode_e'(m);
      u_dma.wr(`PSCU_ADR_UPD_CTRL, 32'h1);
      rdc("unlock_set", `PSCU_ADR_UPD_CTRL, 32'h1);
      n = nd;
      k = npd;
      pst(1);
      chk("apply_period", npd - k, 32'h1);
      chk("apply_duty", nd - n, {31'h0, m == 0});
      rdc("unlock_clr", `PSCU_ADR_UPD_CTRL, 32'h0);
    end
    $display("test unlock finished");
    sync_update_mode <= PSCU_MODE_AUTO;
    u_dma.wr(`PSCU_ADR_UPD_PERIOD, 32'h0);
    gap(n);
    gap(n);
    chk("gap_zero", n, 32'h1);
    rdc("ready", `PSCU_ADR_IRQ_STAT, 32'h1);
    rdc("ready_clr", `PSCU_ADR_IRQ_STAT, 32'h0);
    v = (rnd() & 32'h7) + 32'h2;
    u_dma.wr(`PSCU_ADR_UPD_PBUF, v);
    rdc("pbuf_wo", `PSCU_ADR_UPD_PBUF, 32'h0);
    gap(n);
    rdc("period_load", `PSCU_ADR_UPD_PERIOD, v);
    pst(1);
    rdc("count", `PSCU_ADR_UPD_PERIOD, v | 32'h10);
    gap(n);
    chk("gap_buf", n, v);
    // a low enable must freeze the counter through period starts
    ce <= 1'b0;
    pst(2);
    ce <= 1'b1;
    rdc("ce_hold", `PSCU_ADR_UPD_PERIOD, v);
    $display("test auto update finished");
    sync_update_mode <= PSCU_MODE_MANUAL;
    u_dma.rd(`PSCU_ADR_IRQ_STAT, r);
    repeat (3) begin
      v = rnd();
      evt(v[7:0], v[15:8]);
      rdc("cmp_flags", `PSCU_ADR_IRQ_STAT, {8'h0, v[15:8], v[7:0], 8'h0});
      rdc("cmp_clr", `PSCU_ADR_IRQ_STAT, 32'h0);
    end
    $display("test flags finished");
    sync_update_mode <= PSCU_MODE_DMA;
    dma_request_mode <= 1'b1;
    dma_cmp_select <= 3'h5;
    n = nr;
    evt(8'h20, 8'h00);
    repeat (2) @(posedge clk);
    chk("dma_req", nr - n, 32'h1);
    u_dma.wr(`PSCU_ADR_DUTY_PORT, v);
    u_dma.wr(`PSCU_ADR_DUTY_PORT, d);
    rdc("ready_match", `PSCU_ADR_IRQ_STAT, 32'h00002001);
    // requests left unserved, so the second update is an underrun
    dma_request_mode <= 1'b0;
    u_dma.wr(`PSCU_ADR_UPD_PERIOD, 32'h0);
    pst(2);
    repeat (4) @(posedge clk);
    rdc("underrun", `PSCU_ADR_IRQ_STAT, 32'h9);
    rdc("underrun_clr", `PSCU_ADR_IRQ_STAT, 32'h0);
    $display("test dma mode finished");
    test_done();
  end
endmodule // pscu_top_tb

bind pscu_top pscu_top_asserts u_chk (.clk, .rstn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_ack_o, .sync_channel_select, .sync_update_mode, .dma_request_mode, .dma_cmp_select, .period_start,
  .cmp_match, .duty_load, .update_apply, .dma_request, .override_value);
